// ### hdl/sbr_cfg.svh
/*
  timing, geometry and encoding constants for the bank command rules block.
  assumes a 50 MHz system clock; times are in ns, counts derive from them.
*/
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH

`define SBR_CLK_NS        20
`define SBR_CYC(ns)       (((ns) + `SBR_CLK_NS - 1) / `SBR_CLK_NS)

`define SBR_BANKS         8
`define SBR_BANK_W        3
`define SBR_BCNT_W        8
`define SBR_DCNT_W        10
`define SBR_REG_ADDR_W    8

// row-close, row-open, refresh and register times, all least times
`define SBR_T_ROW_CLOSE_NS        18
`define SBR_T_ROW_OPEN_NS         18
`define SBR_T_SINGLE_REFRESH_NS   60
`define SBR_T_ALL_REFRESH_NS      130
`define SBR_T_REG_READ_NS         40
`define SBR_T_REG_WRITE_NS        100
`define SBR_T_INIT_NS             10000
`define SBR_T_EXIT_NS             8
`define SBR_BURST_CYC             4

// config register address that carries the self-initialize command
`define SBR_SELF_INIT_ADDR        8'h3f

`endif

// ### hdl/sbr_pkg.sv
/*
  types for the bank command rules block: commands, bank and device states.
  assumes sbr_cfg.svh supplies all numeric constants.
*/
`default_nettype none

package sbr_pkg;

  typedef enum logic [3:0] {
    SBR_CMD_NOP         = 4'h0,
    SBR_CMD_ROW_OPEN    = 4'h1,
    SBR_CMD_READ        = 4'h2,
    SBR_CMD_WRITE       = 4'h3,
    SBR_CMD_ROW_CLOSE   = 4'h4,
    SBR_CMD_REFRESH     = 4'h5,
    SBR_CMD_CFG_READ    = 4'h6,
    SBR_CMD_CFG_WRITE   = 4'h7,
    SBR_CMD_BURST_STOP  = 4'h8
  } sbr_cmd_e;

  typedef enum logic [3:0] {
    SBR_B_IDLE       = 4'h0,
    SBR_B_OPENING    = 4'h1,
    SBR_B_ACTIVE     = 4'h2,
    SBR_B_READING    = 4'h3,
    SBR_B_WRITING    = 4'h4,
    SBR_B_READING_AC = 4'h5,
    SBR_B_WRITING_AC = 4'h6,
    SBR_B_CLOSING    = 4'h7,
    SBR_B_REFRESHING = 4'h8
  } sbr_bank_e;

  typedef enum logic [3:0] {
    SBR_D_POWER_ON    = 4'h0,
    SBR_D_RESETTING   = 4'h1,
    SBR_D_NORMAL      = 4'h2,
    SBR_D_REFRESH_ALL = 4'h3,
    SBR_D_RD_IDLE     = 4'h4,
    SBR_D_RD_RESET    = 4'h5,
    SBR_D_RD_ACTIVE   = 4'h6,
    SBR_D_REG_WRITE   = 4'h7,
    SBR_D_CLOSE_ALL   = 4'h8
  } sbr_dev_e;

endpackage

`default_nettype wire

// ### hdl/sbr_bank_rules.sv
/*
  per-bank and device-wide command legality and state tracking for a
  low-power ddr sdram. assumes commands arrive synchronous to clk_sys, one per
  cycle, with nop encoded as zero; no low-power state is modelled here.
*/
// Summary of operation
// - read with auto-close keeps bank busy through burst and row-close time, then idle.
// - write with auto-close keeps bank busy through burst and row-close time, then idle.
// - single-bank refresh keeps that bank busy for single_bank_refresh_time, then idle.
// - all-bank refresh keeps device busy for all_bank_refresh_time, then all idle.
// - config_register_read from idle or resetting lasts register_read_time, then all idle.
// - config_register_read with a row open lasts register_read_time, banks stay active.
// - config_register_write to any address but the self-initialize one lasts register_write_time, then device is all idle.
// - close-all-banks keeps device busy for row-close time, then all idle.
// - row-close to an idle bank still imposes the full row-close wait.
// - follow-on read or write may have auto_close on or off; both accepted.
// - burst_stop ends the burst of the latest read or write without auto-close, any bank.
// - in power-on, self_initialize_command starts initialization and enters resetting.
// - while resetting, config_register_read is accepted and enters resetting read state.
// - other banks accept open, read, write, close while one bank is busy.
// - config_register_read accepted while banks open or closing; idle or active read.
// - burst_stop returns the bursting bank to active.
// - with one bank idle, others accept whatever their own state supports.
// - commands count only with cke high on two edges and exit time elapsed.
`timescale 1ns/1ps
`include "sbr_cfg.svh"
`default_nettype none

module sbr_bank_rules (
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  input  wire logic                             cke,
  input  wire sbr_pkg::sbr_cmd_e                cmd,
  input  wire logic [`SBR_BANK_W-1:0]           cmd_bank,
  input  wire logic                             cmd_all,
  input  wire logic                             cmd_auto_close,
  input  wire logic [`SBR_REG_ADDR_W-1:0]       cmd_reg_addr,
  output logic [4*`SBR_BANKS-1:0]               bank_state,
  output sbr_pkg::sbr_dev_e                     dev_state,
  output logic                                  cmd_accepted,
  output logic                                  cmd_illegal
);

  localparam int K_RP   = `SBR_CYC(`SBR_T_ROW_CLOSE_NS);
  localparam int K_RCD  = `SBR_CYC(`SBR_T_ROW_OPEN_NS);
  localparam int K_RFPB = `SBR_CYC(`SBR_T_SINGLE_REFRESH_NS);
  localparam int K_RFAB = `SBR_CYC(`SBR_T_ALL_REFRESH_NS);
  localparam int K_MRR  = `SBR_CYC(`SBR_T_REG_READ_NS);
  localparam int K_MRW  = `SBR_CYC(`SBR_T_REG_WRITE_NS);
  localparam int K_INIT = `SBR_CYC(`SBR_T_INIT_NS);
  localparam int K_XP   = `SBR_CYC(`SBR_T_EXIT_NS);
  localparam int K_BST  = `SBR_BURST_CYC;
  localparam int K_AC   = K_BST + K_RP;

  typedef logic [`SBR_BCNT_W-1:0] sbr_bcnt_t;
  typedef logic [`SBR_DCNT_W-1:0] sbr_dcnt_t;

  sbr_pkg::sbr_bank_e [`SBR_BANKS-1:0] bank_q, bank_d;
  sbr_bcnt_t          [`SBR_BANKS-1:0] bcnt_q, bcnt_d;
  sbr_pkg::sbr_dev_e                   dev_q, dev_d;
  sbr_dcnt_t                           dcnt_q, dcnt_d;
  logic [`SBR_BANK_W-1:0]              last_q, last_d;
  logic                                cke_prev_q;
  sbr_dcnt_t                           xcnt_q, xcnt_d;
  logic                                acc_q, bad_q;
  logic                                acc, bad, cke_ok, self_init;
  sbr_pkg::sbr_bank_e                  cs;

  // where a timed state settles once its counter runs out
  function automatic sbr_pkg::sbr_bank_e settle(input sbr_pkg::sbr_bank_e s);
    unique case (s)
      sbr_pkg::SBR_B_OPENING, sbr_pkg::SBR_B_READING,
      sbr_pkg::SBR_B_WRITING:   settle = sbr_pkg::SBR_B_ACTIVE;
      default:                  settle = sbr_pkg::SBR_B_IDLE;
    endcase
  endfunction

  function automatic logic all_in(input sbr_pkg::sbr_bank_e [`SBR_BANKS-1:0] s, input logic allow_active);
    all_in = 1'b1;
    for (int i = 0; i < `SBR_BANKS; i++) begin
      if (!(s[i] == sbr_pkg::SBR_B_IDLE || (allow_active && s[i] == sbr_pkg::SBR_B_ACTIVE))) begin
        all_in = 1'b0;
      end
    end
  endfunction

  // banks that may sit beside a register read: idle, opening, open, closing
  function automatic logic quiet_banks(input sbr_pkg::sbr_bank_e [`SBR_BANKS-1:0] s);
    quiet_banks = 1'b1;
    for (int i = 0; i < `SBR_BANKS; i++) begin
      if (!(s[i] inside {sbr_pkg::SBR_B_IDLE, sbr_pkg::SBR_B_OPENING,
                         sbr_pkg::SBR_B_ACTIVE, sbr_pkg::SBR_B_CLOSING})) begin
        quiet_banks = 1'b0;
      end
    end
  endfunction

  assign cke_ok    = cke && cke_prev_q && (xcnt_q == '0);
  assign self_init = (cmd == sbr_pkg::SBR_CMD_CFG_WRITE) && (cmd_reg_addr == `SBR_SELF_INIT_ADDR);
  assign cs        = bank_q[cmd_bank];

  // exit-time counter restarts on every rising cke
  always_comb begin
    xcnt_d = xcnt_q;
    if (cke && !cke_prev_q) begin
      xcnt_d = sbr_dcnt_t'(K_XP);
    end else if (xcnt_q != '0) begin
      xcnt_d = xcnt_q - sbr_dcnt_t'(1);
    end
  end

  always_comb begin
    bank_d = bank_q;
    bcnt_d = bcnt_q;
    dev_d  = dev_q;
    dcnt_d = dcnt_q;
    last_d = last_q;
    acc    = 1'b0;
    bad    = 1'b0;
    for (int b = 0; b < `SBR_BANKS; b++) begin
      if (bcnt_q[b] != '0) begin
        bcnt_d[b] = bcnt_q[b] - sbr_bcnt_t'(1);
        if (bcnt_q[b] == sbr_bcnt_t'(1)) begin
          bank_d[b] = settle(bank_q[b]);
        end
      end
    end
    if (dcnt_q != '0) begin
      dcnt_d = dcnt_q - sbr_dcnt_t'(1);
      if (dcnt_q == sbr_dcnt_t'(1)) begin
        dev_d = sbr_pkg::SBR_D_NORMAL;
      end
    end
    if (cmd != sbr_pkg::SBR_CMD_NOP) begin
      bad = 1'b1;
      if (cke_ok) begin
        unique case (dev_q)
          sbr_pkg::SBR_D_POWER_ON: begin
            if (self_init) begin
              dev_d  = sbr_pkg::SBR_D_RESETTING;
              dcnt_d = sbr_dcnt_t'(K_INIT);
              bad    = 1'b0;
            end
          end
          sbr_pkg::SBR_D_RESETTING: begin
            if (cmd == sbr_pkg::SBR_CMD_CFG_READ) begin
              dev_d  = sbr_pkg::SBR_D_RD_RESET;
              dcnt_d = sbr_dcnt_t'(K_MRR);
              bad    = 1'b0;
            end
          end
          sbr_pkg::SBR_D_NORMAL: begin
            unique case (cmd)
              sbr_pkg::SBR_CMD_ROW_OPEN: begin
                if (cs == sbr_pkg::SBR_B_IDLE) begin
                  bank_d[cmd_bank] = sbr_pkg::SBR_B_OPENING;
                  bcnt_d[cmd_bank] = sbr_bcnt_t'(K_RCD);
                  bad              = 1'b0;
                end
              end
              sbr_pkg::SBR_CMD_READ, sbr_pkg::SBR_CMD_WRITE: begin
                if (cs inside {sbr_pkg::SBR_B_ACTIVE, sbr_pkg::SBR_B_READING, sbr_pkg::SBR_B_WRITING}) begin
                  // follow-on bursts take either auto_close setting
                  if (cmd == sbr_pkg::SBR_CMD_READ) begin
                    bank_d[cmd_bank] = cmd_auto_close ? sbr_pkg::SBR_B_READING_AC : sbr_pkg::SBR_B_READING;
                  end else begin
                    bank_d[cmd_bank] = cmd_auto_close ? sbr_pkg::SBR_B_WRITING_AC : sbr_pkg::SBR_B_WRITING;
                  end
                  bcnt_d[cmd_bank] = sbr_bcnt_t'(cmd_auto_close ? K_AC : K_BST);
                  last_d           = cmd_bank;
                  bad              = 1'b0;
                end
              end
              sbr_pkg::SBR_CMD_ROW_CLOSE: begin
                if (cmd_all) begin
                  if (all_in(bank_q, 1'b1)) begin
                    for (int b = 0; b < `SBR_BANKS; b++) begin
                      bank_d[b] = sbr_pkg::SBR_B_CLOSING;
                      bcnt_d[b] = sbr_bcnt_t'(K_RP);
                    end
                    dev_d  = sbr_pkg::SBR_D_CLOSE_ALL;
                    dcnt_d = sbr_dcnt_t'(K_RP);
                    bad    = 1'b0;
                  end
                end else if (cs == sbr_pkg::SBR_B_IDLE || cs == sbr_pkg::SBR_B_ACTIVE) begin
                  bank_d[cmd_bank] = sbr_pkg::SBR_B_CLOSING;
                  bcnt_d[cmd_bank] = sbr_bcnt_t'(K_RP);
                  bad              = 1'b0;
                end
              end
              sbr_pkg::SBR_CMD_REFRESH: begin
                if (cmd_all) begin
                  if (all_in(bank_q, 1'b0)) begin
                    dev_d  = sbr_pkg::SBR_D_REFRESH_ALL;
                    dcnt_d = sbr_dcnt_t'(K_RFAB);
                    bad    = 1'b0;
                  end
                end else if (cs == sbr_pkg::SBR_B_IDLE) begin
                  bank_d[cmd_bank] = sbr_pkg::SBR_B_REFRESHING;
                  bcnt_d[cmd_bank] = sbr_bcnt_t'(K_RFPB);
                  bad              = 1'b0;
                end
              end
              sbr_pkg::SBR_CMD_CFG_READ: begin
                if (all_in(bank_q, 1'b0)) begin
                  dev_d  = sbr_pkg::SBR_D_RD_IDLE;
                  dcnt_d = sbr_dcnt_t'(K_MRR);
                  bad    = 1'b0;
                end else if (quiet_banks(bank_q)) begin
                  dev_d  = sbr_pkg::SBR_D_RD_ACTIVE;
                  dcnt_d = sbr_dcnt_t'(K_MRR);
                  bad    = 1'b0;
                end
              end
              sbr_pkg::SBR_CMD_CFG_WRITE: begin
                if (all_in(bank_q, 1'b0)) begin
                  dev_d  = self_init ? sbr_pkg::SBR_D_RESETTING : sbr_pkg::SBR_D_REG_WRITE;
                  dcnt_d = sbr_dcnt_t'(self_init ? K_INIT : K_MRW);
                  bad    = 1'b0;
                end
              end
              sbr_pkg::SBR_CMD_BURST_STOP: begin
                if (bank_q[last_q] inside {sbr_pkg::SBR_B_READING, sbr_pkg::SBR_B_WRITING}) begin
                  bank_d[last_q] = sbr_pkg::SBR_B_ACTIVE;
                  bcnt_d[last_q] = '0;
                  bad            = 1'b0;
                end
              end
              default: bad = 1'b1;
            endcase
          end
          // busy device states refuse everything but nop
          default: bad = 1'b1;
        endcase
      end
      acc = !bad;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_q     <= '{default: sbr_pkg::SBR_B_IDLE};
      bcnt_q     <= '0;
      dev_q      <= sbr_pkg::SBR_D_POWER_ON;
      dcnt_q     <= '0;
      last_q     <= '0;
      cke_prev_q <= 1'b0;
      xcnt_q     <= '0;
      acc_q      <= 1'b0;
      bad_q      <= 1'b0;
    end else begin
      bank_q     <= bank_d;
      bcnt_q     <= bcnt_d;
      dev_q      <= dev_d;
      dcnt_q     <= dcnt_d;
      last_q     <= last_d;
      cke_prev_q <= cke;
      xcnt_q     <= xcnt_d;
      acc_q      <= acc;
      bad_q      <= bad;
    end
  end

  assign bank_state   = bank_q;
  assign dev_state    = dev_q;
  assign cmd_accepted = acc_q;
  assign cmd_illegal  = bad_q;

  // per-bank checks watch bank 0 only, except burst stop, which follows last_q; all banks share the same logic
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ap_read_idle: assert property (acc && cmd == sbr_pkg::SBR_CMD_READ && cmd_auto_close && cmd_bank == '0
    |-> ##K_AC bank_q[0] == sbr_pkg::SBR_B_READING_AC ##1 bank_q[0] == sbr_pkg::SBR_B_IDLE)
    else $error("auto-close read did not settle to idle on time");
  a_ap_write_idle: assert property (acc && cmd == sbr_pkg::SBR_CMD_WRITE && cmd_auto_close && cmd_bank == '0
    |-> ##K_AC bank_q[0] == sbr_pkg::SBR_B_WRITING_AC ##1 bank_q[0] == sbr_pkg::SBR_B_IDLE)
    else $error("auto-close write did not settle to idle on time");
  a_busy_refuse: assert property (dev_q inside {sbr_pkg::SBR_D_REFRESH_ALL, sbr_pkg::SBR_D_REG_WRITE,
    sbr_pkg::SBR_D_CLOSE_ALL, sbr_pkg::SBR_D_RD_IDLE, sbr_pkg::SBR_D_RD_RESET, sbr_pkg::SBR_D_RD_ACTIVE}
    && cmd != sbr_pkg::SBR_CMD_NOP |=> cmd_illegal && !cmd_accepted)
    else $error("command taken during busy device state");
  a_pb_refresh: assert property (acc && cmd == sbr_pkg::SBR_CMD_REFRESH && !cmd_all && cmd_bank == '0
    |=> bank_q[0] == sbr_pkg::SBR_B_REFRESHING [*3] ##1 bank_q[0] == sbr_pkg::SBR_B_IDLE)
    else $error("single-bank refresh time wrong");
  a_ab_refresh: assert property (acc && cmd == sbr_pkg::SBR_CMD_REFRESH && cmd_all
    |-> ##K_RFAB dev_q == sbr_pkg::SBR_D_REFRESH_ALL ##1 dev_q == sbr_pkg::SBR_D_NORMAL)
    else $error("all-bank refresh time wrong");
  a_rr_idle: assert property ($rose(dev_q == sbr_pkg::SBR_D_RD_IDLE)
    |-> dev_q == sbr_pkg::SBR_D_RD_IDLE [*2] ##1 dev_q == sbr_pkg::SBR_D_NORMAL)
    else $error("register read time wrong");
  a_rr_active: assert property (acc && cmd == sbr_pkg::SBR_CMD_CFG_READ
    && bank_q[0] == sbr_pkg::SBR_B_ACTIVE
    |=> dev_q == sbr_pkg::SBR_D_RD_ACTIVE ##K_MRR bank_q[0] == sbr_pkg::SBR_B_ACTIVE)
    else $error("active register read lost the open row");
  a_rw_done: assert property (acc && cmd == sbr_pkg::SBR_CMD_CFG_WRITE && !self_init
    |-> ##K_MRW dev_q == sbr_pkg::SBR_D_REG_WRITE ##1 dev_q == sbr_pkg::SBR_D_NORMAL)
    else $error("register write time wrong");
  a_close_all: assert property (acc && cmd == sbr_pkg::SBR_CMD_ROW_CLOSE && cmd_all
    |=> dev_q == sbr_pkg::SBR_D_CLOSE_ALL ##K_RP dev_q == sbr_pkg::SBR_D_NORMAL && bank_q[0] == sbr_pkg::SBR_B_IDLE)
    else $error("close-all did not end all idle");
  a_close_idle: assert property (acc && cmd == sbr_pkg::SBR_CMD_ROW_CLOSE && !cmd_all && cmd_bank == '0
    && bank_q[0] == sbr_pkg::SBR_B_IDLE |=> bank_q[0] == sbr_pkg::SBR_B_CLOSING)
    else $error("close of idle bank skipped the wait");
  a_stop_active: assert property (acc && cmd == sbr_pkg::SBR_CMD_BURST_STOP
    |=> bank_q[$past(last_q)] == sbr_pkg::SBR_B_ACTIVE)
    else $error("burst stop did not return bank to active");
  a_self_init: assert property (dev_q == sbr_pkg::SBR_D_POWER_ON && cke_ok && self_init
    |=> dev_q == sbr_pkg::SBR_D_RESETTING && cmd_accepted)
    else $error("self-initialize not taken at power-on");
  a_reset_read: assert property (dev_q == sbr_pkg::SBR_D_RESETTING && cke_ok
    && cmd == sbr_pkg::SBR_CMD_CFG_READ
    |=> dev_q == sbr_pkg::SBR_D_RD_RESET)
    else $error("register read refused while resetting");
  a_cke_gate: assert property (!cke_ok |=> !cmd_accepted)
    else $error("command taken without stable clock enable");

  c_ap_read: cover property (acc && cmd == sbr_pkg::SBR_CMD_READ && cmd_auto_close);
  c_two_banks: cover property (bank_q[0] == sbr_pkg::SBR_B_READING && bank_q[1] == sbr_pkg::SBR_B_OPENING);
  c_stop: cover property (acc && cmd == sbr_pkg::SBR_CMD_BURST_STOP);
  c_init_read: cover property (dev_q == sbr_pkg::SBR_D_RD_RESET);

endmodule

`default_nettype wire

// ### bench/sbr_ctrl_model.sv
/*
  controller model: drives one command per cycle into the bank rules block.
  assumes the bench calls its tasks; all lines change on the falling clock edge.
*/
`timescale 1ns/1ps
`include "sbr_cfg.svh"
`default_nettype none

module sbr_ctrl_model (
  input  wire logic                       clk_sys,
  output var logic                        cke,
  output var sbr_pkg::sbr_cmd_e           cmd,
  output var logic [`SBR_BANK_W-1:0]      cmd_bank,
  output var logic                        cmd_all,
  output var logic                        cmd_auto_close,
  output var logic [`SBR_REG_ADDR_W-1:0]  cmd_reg_addr
);
  initial begin
    cke            = 1'b0;
    cmd            = sbr_pkg::SBR_CMD_NOP;
    cmd_bank       = 3'h0;
    cmd_all        = 1'b0;
    cmd_auto_close = 1'b0;
    cmd_reg_addr   = 8'h00;
  end

  // one command for one cycle; the bench also sends illegal ones to check refusal
  // self-initialize goes out as a register write
  task automatic send(input sbr_pkg::sbr_cmd_e c, input logic [`SBR_BANK_W-1:0] b,
                      input logic a, input logic ac, input logic [`SBR_REG_ADDR_W-1:0] ad);
    @(negedge clk_sys);
    cke            = 1'b1;
    cmd            = c;
    cmd_bank       = b;
    cmd_all        = a;
    cmd_auto_close = ac;
    cmd_reg_addr   = ad;
  endtask

  // nop only while busy qualifiers toggle so nothing leans on stale values
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      cmd            = sbr_pkg::SBR_CMD_NOP;
      cmd_bank       = ~cmd_bank;
      cmd_all        = ~cmd_all;
      cmd_auto_close = ~cmd_auto_close;
      cmd_reg_addr   = ~cmd_reg_addr;
    end
  endtask

  // clock-enable change with a nop on the same edge
  task automatic power(input logic v);
    @(negedge clk_sys);
    cke = v;
    cmd = sbr_pkg::SBR_CMD_NOP;
  endtask
endmodule
`default_nettype wire

// ### bench/sbr_bank_rules_test.sv
/*
  self-checking bench for the bank rules block: a table of single commands,
  then cross-bank, burst-stop, clock-enable and reset cases.
  assumes sbr_ctrl_model drives the command port on falling edges.
*/
`timescale 1ns/1ps
`include "sbr_cfg.svh"
`default_nettype none

module sbr_bank_rules_test;
  typedef struct {
    sbr_pkg::sbr_cmd_e c;
    logic [2:0]        b;
    logic              a;
    logic              ac;
    logic [7:0]        ad;
    logic              dev;
    logic [3:0]        busy;
    int                dur;
    logic [3:0]        fin;
  } sbr_row_s;

  logic                            clk_sys;
  logic                            rst;
  logic                            cke;
  sbr_pkg::sbr_cmd_e               cmd;
  logic [`SBR_BANK_W-1:0]          cmd_bank;
  logic                            cmd_all;
  logic                            cmd_auto_close;
  logic [`SBR_REG_ADDR_W-1:0]      cmd_reg_addr;
  logic [4*`SBR_BANKS-1:0]         bank_state;
  sbr_pkg::sbr_dev_e               dev_state;
  logic                            cmd_accepted;
  logic                            cmd_illegal;
  int                              errors;
  int                              n_tests;
  int                              cycles = 0;
  sbr_row_s                        rows [11];

  sbr_ctrl_model i_ctrl (.clk_sys(clk_sys), .cke(cke), .cmd(cmd), .cmd_bank(cmd_bank), .cmd_all(cmd_all),
                         .cmd_auto_close(cmd_auto_close), .cmd_reg_addr(cmd_reg_addr));

  sbr_bank_rules i_dut (.clk_sys(clk_sys), .rst(rst), .cke(cke), .cmd(cmd), .cmd_bank(cmd_bank),
                        .cmd_all(cmd_all), .cmd_auto_close(cmd_auto_close), .cmd_reg_addr(cmd_reg_addr),
                        .bank_state(bank_state), .dev_state(dev_state), .cmd_accepted(cmd_accepted),
                        .cmd_illegal(cmd_illegal));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [3:0] obs(input logic d, input logic [2:0] b);
    return d ? 4'(dev_state) : bank_state[4*b +: 4];
  endfunction

  task automatic op(input sbr_pkg::sbr_cmd_e c, input logic [2:0] b, input logic ac);
    i_ctrl.send(c, b, 1'b0, ac, 8'h00);
  endtask

  // hang guard: the whole run needs under 120 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    errors = 0;
    n_tests = 0;
    // cmd, bank, all, auto_close, addr, dev view, busy state, cycle of final state, final state
    rows[0]  = '{sbr_pkg::SBR_CMD_REFRESH,    3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 4'h8, 4, 4'h0};
    rows[1]  = '{sbr_pkg::SBR_CMD_REFRESH,    3'h0, 1'b1, 1'b0, 8'h00, 1'b1, 4'h3, 8, 4'h2};
    rows[2]  = '{sbr_pkg::SBR_CMD_CFG_READ,   3'h0, 1'b0, 1'b0, 8'h05, 1'b1, 4'h4, 3, 4'h2};
    rows[3]  = '{sbr_pkg::SBR_CMD_CFG_WRITE,  3'h0, 1'b0, 1'b0, 8'h0a, 1'b1, 4'h7, 6, 4'h2};
    rows[4]  = '{sbr_pkg::SBR_CMD_ROW_CLOSE,  3'h0, 1'b1, 1'b0, 8'h00, 1'b1, 4'h8, 2, 4'h2};
    rows[5]  = '{sbr_pkg::SBR_CMD_ROW_CLOSE,  3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 4'h7, 2, 4'h0};
    rows[6]  = '{sbr_pkg::SBR_CMD_ROW_OPEN,   3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 4'h1, 2, 4'h2};
    rows[7]  = '{sbr_pkg::SBR_CMD_READ,       3'h0, 1'b0, 1'b1, 8'h00, 1'b0, 4'h5, 6, 4'h0};
    rows[8]  = '{sbr_pkg::SBR_CMD_ROW_OPEN,   3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 4'h1, 2, 4'h2};
    rows[9]  = '{sbr_pkg::SBR_CMD_WRITE,      3'h0, 1'b0, 1'b1, 8'h00, 1'b0, 4'h6, 6, 4'h0};
    rows[10] = '{sbr_pkg::SBR_CMD_ROW_OPEN,   3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 4'h1, 2, 4'h2};
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    i_ctrl.power(1'b1);
    check("reset dev", 4'(dev_state), 4'h0);
    check("reset banks", 4'(|bank_state), 4'h0);
    i_ctrl.idle(3);
    op(sbr_pkg::SBR_CMD_ROW_OPEN, 3'h0, 1'b0);
    i_ctrl.idle(1);
    check("power-on refusal", 4'(cmd_illegal), 4'h1);
    i_ctrl.send(sbr_pkg::SBR_CMD_CFG_WRITE, 3'h0, 1'b0, 1'b0, `SBR_SELF_INIT_ADDR);
    op(sbr_pkg::SBR_CMD_CFG_READ, 3'h0, 1'b0);
    check("self init", 4'(dev_state), 4'h1);
    i_ctrl.idle(1);
    check("reset reg read", 4'(dev_state), 4'h5);
    i_ctrl.idle(2);
    check("reset read end", 4'(dev_state), 4'h2);
    // table: one command at a time from all idle, except the auto-close read and write, which follow a row open
    foreach (rows[i]) begin
      i_ctrl.send(rows[i].c, rows[i].b, rows[i].a, rows[i].ac, rows[i].ad);
      i_ctrl.idle(1);
      check("row accepted", 4'(cmd_accepted), 4'h1);
      check("row busy", obs(rows[i].dev, rows[i].b), rows[i].busy);
      for (int k = 2; k <= rows[i].dur; k++) begin
        i_ctrl.idle(1);
        check("row state", obs(rows[i].dev, rows[i].b), (k < rows[i].dur) ? rows[i].busy : rows[i].fin);
      end
    end
    // burst stop sent with another bank field still ends the latest burst
    op(sbr_pkg::SBR_CMD_READ, 3'h0, 1'b0);
    op(sbr_pkg::SBR_CMD_ROW_OPEN, 3'h3, 1'b0);
    op(sbr_pkg::SBR_CMD_BURST_STOP, 3'h3, 1'b0);
    check("open beside read", bank_state[15:12], 4'h1);
    check("read beside open", bank_state[3:0], 4'h3);
    i_ctrl.idle(1);
    check("burst stop", bank_state[3:0], 4'h2);
    check("other bank open", bank_state[15:12], 4'h2);
    // follow-on read switches to auto-close mid-burst
    op(sbr_pkg::SBR_CMD_READ, 3'h0, 1'b0);
    op(sbr_pkg::SBR_CMD_READ, 3'h0, 1'b1);
    i_ctrl.idle(1);
    check("follow-on ac", bank_state[3:0], 4'h5);
    i_ctrl.idle(5);
    check("ac read end", bank_state[3:0], 4'h0);
    // register read with rows open; device refuses meanwhile
    op(sbr_pkg::SBR_CMD_ROW_OPEN, 3'h0, 1'b0);
    i_ctrl.idle(1);
    op(sbr_pkg::SBR_CMD_CFG_READ, 3'h0, 1'b0);
    op(sbr_pkg::SBR_CMD_ROW_OPEN, 3'h4, 1'b0);
    check("active reg read", 4'(dev_state), 4'h6);
    i_ctrl.idle(1);
    check("busy refusal", 4'(cmd_illegal), 4'h1);
    i_ctrl.idle(1);
    check("reg read end", 4'(dev_state), 4'h2);
    check("row kept open", bank_state[15:12], 4'h2);
    // cke low on the previous edge voids the command
    i_ctrl.power(1'b0);
    op(sbr_pkg::SBR_CMD_ROW_OPEN, 3'h4, 1'b0);
    i_ctrl.idle(1);
    check("cke refusal", 4'(cmd_illegal), 4'h1);
    i_ctrl.idle(2);
    op(sbr_pkg::SBR_CMD_ROW_OPEN, 3'h4, 1'b0);
    i_ctrl.idle(1);
    check("cke resumed", bank_state[19:16], 4'h1);
    // all-bank refresh with rows open is refused
    i_ctrl.send(sbr_pkg::SBR_CMD_REFRESH, 3'h0, 1'b1, 1'b0, 8'h00);
    i_ctrl.idle(1);
    check("refresh all refused", 4'(cmd_illegal), 4'h1);
    check("refresh all no busy", 4'(dev_state), 4'h2);
    // second reset mid-run
    rst = 1'b1;
    i_ctrl.idle(2);
    rst = 1'b0;
    i_ctrl.idle(1);
    check("rerun dev", 4'(dev_state), 4'h0);
    check("rerun banks", 4'(|bank_state), 4'h0);
    // plain register write at power-on is not a self-initialize
    i_ctrl.send(sbr_pkg::SBR_CMD_CFG_WRITE, 3'h0, 1'b0, 1'b0, 8'h01);
    i_ctrl.idle(1);
    check("plain write at power-on", 4'(cmd_illegal), 4'h1);
    check("still power-on", 4'(dev_state), 4'h0);
    final_report();
  end
endmodule
`default_nettype wire
